/* src/mclk_divider.v */
`timescale 1ns/1ps
`include "sar_scan_clock_map.vh"

module mclk_divider (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // control
    input  wire       enable,
    input  wire [6:0] div_sel,
    // tick in and out
    input  wire       in_tick,
    output reg        out_tick_ff
);

    reg  [6:0] count_ff;
    reg  [6:0] nxt_count;
    reg        nxt_out_tick;
    wire [6:0] last_count;

    // zero selects divide by 128
    assign last_count = (div_sel == 7'h00) ? `DIV_ZERO_LAST : (div_sel - 7'h01);

    // count master clock edges up to the last count
    always @* begin
        nxt_count    = count_ff;
        nxt_out_tick = 1'b0;
        if (!enable) begin
            nxt_count = 7'h00;
        end else if (in_tick) begin
            if (count_ff >= last_count) begin
                nxt_count    = 7'h00;
                nxt_out_tick = 1'b1;
            end else begin
                nxt_count = count_ff + 7'h01;
            end
        end
    end

    // state registers
    always @(posedge clock) begin
        if (rst) begin
            count_ff    <= 7'h00;
            out_tick_ff <= 1'b0;
        end else begin
            count_ff    <= nxt_count;
            out_tick_ff <= nxt_out_tick;
        end
    end

endmodule // mclk_divider

/* src/sar_adc_scan_clock_readout_ctrl.v */
`timescale 1ns/1ps
`include "sar_scan_clock_map.vh"

module sar_adc_scan_clock_readout_ctrl #(
    parameter [29:0] TICKS_PER_CMIN = `SCAN_TICKS_PER_CMIN
) (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_ff,
    output reg        reg_rvalid_ff,
    // external master clock pin
    input  wire       mclk_pin,
    // auto-scan sequencing
    input  wire       auto_scan_en,
    input  wire       scan_round_done,
    output reg        scan_start_ff,
    output reg        scan_delay_busy_ff,
    // converter clock enable
    output reg        sar_clk_en_ff,
    // result readout
    input  wire       spi_read_active,
    output reg        spi_readout_sel_ff,
    output reg        i2c_readout_sel_ff,
    output reg        result_update_en_ff
);

    // scan sequencer states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    // register reset images, sliced into the field flops
    localparam [7:0] SCAN_RST = `SCAN_TIMER_RESET;
    localparam [7:0] CLK_RST  = `CLK_CTRL_RESET;
    localparam [7:0] HOLD_RST = `HOLD_CTRL_RESET;

    // delay code to hundredths of a minute
    function [10:0] scan_delay_cmin;
        input [2:0] code;
        begin
            case (code)
                3'h0:    scan_delay_cmin = `SCAN_DLY0_CMIN;
                3'h1:    scan_delay_cmin = `SCAN_DLY1_CMIN;
                3'h2:    scan_delay_cmin = `SCAN_DLY2_CMIN;
                3'h3:    scan_delay_cmin = `SCAN_DLY3_CMIN;
                3'h4:    scan_delay_cmin = `SCAN_DLY4_CMIN;
                3'h5:    scan_delay_cmin = `SCAN_DLY5_CMIN;
                3'h6:    scan_delay_cmin = `SCAN_DLY6_CMIN;
                default: scan_delay_cmin = `SCAN_DLY7_CMIN;
            endcase
        end
    endfunction

    // configuration registers
    reg        scan_dly_en_ff;
    reg  [2:0] scan_sel_ff;
    reg        clk_src_ff;
    reg  [6:0] clk_div_ff;
    reg        rd_port_ff;
    reg        hold_mode_ff;
    reg        sw_hold_ff;

    // master clock pin synchroniser and edge detect
    reg        mclk_meta_ff;
    reg        mclk_sync_ff;
    reg        mclk_prev_ff;
    wire       mclk_edge;

    // internal oscillator emulation
    reg  [6:0] osc_acc_ff;
    reg  [6:0] nxt_osc_acc;
    reg        osc_tick_ff;
    reg        nxt_osc_tick;
    reg  [3:0] osc_base_cnt_ff;
    reg  [3:0] nxt_osc_base_cnt;
    reg        osc_base_tick_ff;
    reg        nxt_osc_base_tick;

    // clock selection
    wire       mclk_div_tick;
    wire       conv_tick;
    wire       base_tick;

    // scan sequencer
    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [29:0] timer_ff;
    reg  [29:0] nxt_timer;
    reg         nxt_scan_start;
    wire [40:0] delay_product;
    wire [29:0] delay_load;

    // readout freeze
    wire       freeze_auto;
    wire       freeze_sw;

    // register readback
    reg  [7:0] nxt_rdata;

    // configuration writes, reserved fields never stored
    always @(posedge clock) begin
        if (rst) begin
            scan_dly_en_ff <= SCAN_RST[`SCAN_DLY_EN_BIT];
            scan_sel_ff    <= SCAN_RST[`SCAN_SEL_MSB:`SCAN_SEL_LSB];
            clk_src_ff     <= CLK_RST[`CLK_SRC_BIT];
            clk_div_ff     <= CLK_RST[`CLK_DIV_MSB:`CLK_DIV_LSB];
            rd_port_ff     <= HOLD_RST[`RD_PORT_BIT];
            hold_mode_ff   <= HOLD_RST[`HOLD_MODE_BIT];
            sw_hold_ff     <= HOLD_RST[`SW_HOLD_BIT];
        end else if (reg_wr) begin
            case (reg_addr)
                `SCAN_TIMER_ADDR: begin
                    scan_dly_en_ff <= reg_wdata[`SCAN_DLY_EN_BIT];
                    scan_sel_ff    <= reg_wdata[`SCAN_SEL_MSB:`SCAN_SEL_LSB];
                end
                `CLK_CTRL_ADDR: begin
                    clk_src_ff <= reg_wdata[`CLK_SRC_BIT];
                    clk_div_ff <= reg_wdata[`CLK_DIV_MSB:`CLK_DIV_LSB];
                end
                `HOLD_CTRL_ADDR: begin
                    rd_port_ff   <= reg_wdata[`RD_PORT_BIT];
                    hold_mode_ff <= reg_wdata[`HOLD_MODE_BIT];
                    sw_hold_ff   <= reg_wdata[`SW_HOLD_BIT];
                end
                default: begin
                    scan_dly_en_ff <= scan_dly_en_ff;
                end
            endcase
        end
    end

    // readback, reserved fields show their reset values
    always @* begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `SCAN_TIMER_ADDR: begin
                nxt_rdata = `SCAN_TIMER_RESET;
                nxt_rdata[`SCAN_DLY_EN_BIT] = scan_dly_en_ff;
                nxt_rdata[`SCAN_SEL_MSB:`SCAN_SEL_LSB] = scan_sel_ff;
            end
            `RSVD_BYTE_ADDR: begin
                nxt_rdata = `RSVD_BYTE_RESET;
            end
            `CLK_CTRL_ADDR: begin
                nxt_rdata[`CLK_SRC_BIT] = clk_src_ff;
                nxt_rdata[`CLK_DIV_MSB:`CLK_DIV_LSB] = clk_div_ff;
            end
            `HOLD_CTRL_ADDR: begin
                nxt_rdata = `HOLD_CTRL_RESET;
                nxt_rdata[`RD_PORT_BIT]   = rd_port_ff;
                nxt_rdata[`HOLD_MODE_BIT] = hold_mode_ff;
                nxt_rdata[`SW_HOLD_BIT]   = sw_hold_ff;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // read data answers one cycle after the strobe
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata_ff  <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // master clock pin through two flops, then rising edge
    always @(posedge clock) begin
        if (rst) begin
            mclk_meta_ff <= 1'b0;
            mclk_sync_ff <= 1'b0;
            mclk_prev_ff <= 1'b0;
        end else begin
            mclk_meta_ff <= mclk_pin;
            mclk_sync_ff <= mclk_meta_ff;
            mclk_prev_ff <= mclk_sync_ff;
        end
    end

    assign mclk_edge = mclk_sync_ff & ~mclk_prev_ff;

    // divided master clock, held idle while the oscillator is chosen
    mclk_divider u_mclk_divider (
        .clock       (clock),
        .rst         (rst),
        .enable      (clk_src_ff),
        .div_sel     (clk_div_ff),
        .in_tick     (mclk_edge),
        .out_tick_ff (mclk_div_tick)
    );

    // 8 mhz oscillator ticks by phase accumulation on the 100 mhz clock
    always @* begin
        nxt_osc_acc  = osc_acc_ff + `OSC_FREQ_MHZ;
        nxt_osc_tick = 1'b0;
        if (osc_acc_ff >= (`CLK_FREQ_MHZ - `OSC_FREQ_MHZ)) begin
            nxt_osc_acc  = osc_acc_ff + `OSC_FREQ_MHZ - `CLK_FREQ_MHZ;
            nxt_osc_tick = 1'b1;
        end
    end

    // oscillator prescaled by eight to the 1 mhz timer base
    always @* begin
        nxt_osc_base_cnt  = osc_base_cnt_ff;
        nxt_osc_base_tick = 1'b0;
        if (osc_tick_ff) begin
            if (osc_base_cnt_ff == (`OSC_BASE_DIV - 4'h1)) begin
                nxt_osc_base_cnt  = 4'h0;
                nxt_osc_base_tick = 1'b1;
            end else begin
                nxt_osc_base_cnt = osc_base_cnt_ff + 4'h1;
            end
        end
    end

    // oscillator registers
    always @(posedge clock) begin
        if (rst) begin
            osc_acc_ff       <= 7'h00;
            osc_tick_ff      <= 1'b0;
            osc_base_cnt_ff  <= 4'h0;
            osc_base_tick_ff <= 1'b0;
        end else begin
            osc_acc_ff       <= nxt_osc_acc;
            osc_tick_ff      <= nxt_osc_tick;
            osc_base_cnt_ff  <= nxt_osc_base_cnt;
            osc_base_tick_ff <= nxt_osc_base_tick;
        end
    end

    // converter clock and timer base from the chosen source
    assign conv_tick = clk_src_ff ? mclk_div_tick : osc_tick_ff;
    assign base_tick = clk_src_ff ? mclk_div_tick : osc_base_tick_ff;

    // converter clock enable pulse
    always @(posedge clock) begin
        if (rst) begin
            sar_clk_en_ff <= 1'b0;
        end else begin
            sar_clk_en_ff <= conv_tick;
        end
    end

    // interval length in base ticks
    assign delay_product = scan_delay_cmin(scan_sel_ff) * TICKS_PER_CMIN;
    assign delay_load    = delay_product[29:0];

    // scan sequencer: start, run, optional interval wait
    always @* begin
        nxt_state      = state_ff;
        nxt_timer      = timer_ff;
        nxt_scan_start = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (auto_scan_en) begin
                    nxt_scan_start = 1'b1;
                    nxt_state      = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!auto_scan_en) begin
                    nxt_state = ST_IDLE;
                end else if (scan_round_done) begin
                    if (scan_dly_en_ff) begin
                        nxt_timer = delay_load;
                        nxt_state = ST_WAIT;
                    end else begin
                        nxt_scan_start = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (!auto_scan_en) begin
                    nxt_state = ST_IDLE;
                end else if (!scan_dly_en_ff) begin
                    nxt_scan_start = 1'b1;
                    nxt_state      = ST_RUN;
                end else if (base_tick) begin
                    if (timer_ff <= 30'h00000001) begin
                        nxt_scan_start = 1'b1;
                        nxt_state      = ST_RUN;
                    end else begin
                        nxt_timer = timer_ff - 30'h00000001;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always @(posedge clock) begin
        if (rst) begin
            state_ff           <= ST_IDLE;
            timer_ff           <= 30'h00000000;
            scan_start_ff      <= 1'b0;
            scan_delay_busy_ff <= 1'b0;
        end else begin
            state_ff           <= nxt_state;
            timer_ff           <= nxt_timer;
            scan_start_ff      <= nxt_scan_start;
            scan_delay_busy_ff <= (nxt_state == ST_WAIT);
        end
    end

    // automatic freeze only for spi readout, software freeze in hold mode
    assign freeze_auto = ~hold_mode_ff & ~rd_port_ff & spi_read_active;
    assign freeze_sw   = hold_mode_ff & sw_hold_ff;

    // readout port selection and result update enable
    always @(posedge clock) begin
        if (rst) begin
            spi_readout_sel_ff  <= 1'b1;
            i2c_readout_sel_ff  <= 1'b0;
            result_update_en_ff <= 1'b1;
        end else begin
            spi_readout_sel_ff  <= ~rd_port_ff;
            i2c_readout_sel_ff  <= rd_port_ff;
            result_update_en_ff <= ~(freeze_auto | freeze_sw);
        end
    end

endmodule // sar_adc_scan_clock_readout_ctrl

/* src/sar_scan_clock_map.vh */
`ifndef SAR_SCAN_CLOCK_MAP_VH
`define SAR_SCAN_CLOCK_MAP_VH

// register offsets
`define SCAN_TIMER_ADDR     8'h0f
`define RSVD_BYTE_ADDR      8'h10
`define CLK_CTRL_ADDR       8'h11
`define HOLD_CTRL_ADDR      8'h12

// reset values
`define SCAN_TIMER_RESET    8'h40
`define RSVD_BYTE_RESET     8'h00
`define CLK_CTRL_RESET      8'h01
`define HOLD_CTRL_RESET     8'h00

// scan interval timer control fields
`define SCAN_RSVD_MSB       7
`define SCAN_RSVD_LSB       4
`define SCAN_DLY_EN_BIT     3
`define SCAN_SEL_MSB        2
`define SCAN_SEL_LSB        0

// converter clock control fields
`define CLK_SRC_BIT         7
`define CLK_DIV_MSB         6
`define CLK_DIV_LSB         0

// readout hold control fields
`define RD_PORT_BIT         7
`define HOLD_MODE_BIT       6
`define SW_HOLD_BIT         5
`define HOLD_RSVD_MSB       4
`define HOLD_RSVD_LSB       0

// clock rates
`define CLK_FREQ_MHZ        7'h64
`define OSC_FREQ_MHZ        7'h08
`define OSC_BASE_DIV        4'h8
`define DIV_ZERO_LAST       7'h7f

// scan delays in hundredths of a minute
`define SCAN_DLY0_CMIN      11'h070
`define SCAN_DLY1_CMIN      11'h150
`define SCAN_DLY2_CMIN      11'h22f
`define SCAN_DLY3_CMIN      11'h30f
`define SCAN_DLY4_CMIN      11'h3e9
`define SCAN_DLY5_CMIN      11'h4ce
`define SCAN_DLY6_CMIN      11'h5ae
`define SCAN_DLY7_CMIN      11'h68e

// base ticks in one hundredth of a minute: 60 s * 1 MHz / 100
`define SCAN_TICKS_PER_CMIN 30'h00927c0

`endif

/* tb/sar_scan_monitor.sv */
`timescale 1ns/1ps
module sar_scan_monitor #(
    parameter [29:0] TICKS_PER_CMIN = 30'h0000001
) (
    // clock and reset
    input wire       clock,
    input wire       rst,
    // register port
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_ff,
    input wire       reg_rvalid_ff,
    // scan, clock and readout
    input wire       mclk_pin,
    input wire       auto_scan_en,
    input wire       scan_round_done,
    input wire       scan_start_ff,
    input wire       scan_delay_busy_ff,
    input wire       sar_clk_en_ff,
    input wire       spi_read_active,
    input wire       spi_readout_sel_ff,
    input wire       i2c_readout_sel_ff,
    input wire       result_update_en_ff
);
    reg       dly_en_ff;
    reg [2:0] hold_ff;
    reg       run_ff;
    wire      freeze;

    // freeze condition from shadowed port, mode and hold bits
    assign freeze = (!hold_ff[1] && !hold_ff[2] && spi_read_active) || (hold_ff[1] && hold_ff[0]);

    // shadow of control bits and whether a round is running
    always @(posedge clock) begin
        if (rst) begin
            dly_en_ff <= 1'b0;
            hold_ff   <= 3'h0;
            run_ff    <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 8'h0f) dly_en_ff <= reg_wdata[3];
            if (reg_wr && reg_addr == 8'h12) hold_ff <= reg_wdata[7:5];
            run_ff <= scan_start_ff || (run_ff && !scan_round_done);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_read_answer: assert property (reg_rd |=> reg_rvalid_ff)
        else $error("read not answered");
    a_rdata_holds: assert property (!reg_rvalid_ff |-> $stable(reg_rdata_ff))
        else $error("read data moved without a read");
    a_start_pulse: assert property (scan_start_ff |=> !scan_start_ff)
        else $error("start longer than one cycle");
    a_done_no_delay: assert property (
        run_ff && scan_round_done && !dly_en_ff && auto_scan_en |=> scan_start_ff)
        else $error("no immediate start with delay off");
    a_done_delay: assert property (
        run_ff && scan_round_done && dly_en_ff && auto_scan_en |=> scan_delay_busy_ff && !scan_start_ff)
        else $error("no interval wait with delay on");
    a_wait_min: assert property ($rose(scan_delay_busy_ff) |-> !scan_start_ff [*8])
        else $error("interval wait ended too early");
    a_freeze_map: assert property (
        !$past(rst) |-> result_update_en_ff == !$past(freeze))
        else $error("update enable does not match hold setting");
    a_port_select: assert property (
        !$past(rst) |-> i2c_readout_sel_ff == $past(hold_ff[2]) && spi_readout_sel_ff == !i2c_readout_sel_ff)
        else $error("readout port select wrong");
    a_clk_single: assert property (sar_clk_en_ff |=> !sar_clk_en_ff)
        else $error("converter clock tick too long");
endmodule // sar_scan_monitor

bind sar_adc_scan_clock_readout_ctrl sar_scan_monitor #(.TICKS_PER_CMIN(TICKS_PER_CMIN)) u_mon (
    .clock               (clock),
    .rst                 (rst),
    .reg_addr            (reg_addr),
    .reg_wr              (reg_wr),
    .reg_wdata           (reg_wdata),
    .reg_rd              (reg_rd),
    .reg_rdata_ff        (reg_rdata_ff),
    .reg_rvalid_ff       (reg_rvalid_ff),
    .mclk_pin            (mclk_pin),
    .auto_scan_en        (auto_scan_en),
    .scan_round_done     (scan_round_done),
    .scan_start_ff       (scan_start_ff),
    .scan_delay_busy_ff  (scan_delay_busy_ff),
    .sar_clk_en_ff       (sar_clk_en_ff),
    .spi_read_active     (spi_read_active),
    .spi_readout_sel_ff  (spi_readout_sel_ff),
    .i2c_readout_sel_ff  (i2c_readout_sel_ff),
    .result_update_en_ff (result_update_en_ff)
);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    // design inputs
    reg        clock = 1'b0;
    reg        rst = 1'b1;
    reg  [7:0] reg_addr = 8'h00;
    reg        reg_wr = 1'b0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_rd = 1'b0;
    reg        mclk_pin = 1'b0;
    reg        auto_scan_en = 1'b0;
    reg        scan_round_done = 1'b0;
    reg        spi_read_active = 1'b0;
    // design outputs
    wire [7:0] reg_rdata_ff;
    wire       reg_rvalid_ff, scan_start_ff, scan_delay_busy_ff, sar_clk_en_ff;
    wire       spi_readout_sel_ff, i2c_readout_sel_ff, result_update_en_ff;
    // bench state
    integer    failures = 0, num_checks = 0, pulses = 0, edges = 0, mph = 0, k, i, e0;
    integer    cmin [0:7] = '{112, 336, 559, 783, 1001, 1230, 1454, 1678};
    reg        mclk_run = 1'b0;
    reg  [7:0] d;

    sar_adc_scan_clock_readout_ctrl #(.TICKS_PER_CMIN(30'h0000001)) dut (
        .clock               (clock),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wr              (reg_wr),
        .reg_wdata           (reg_wdata),
        .reg_rd              (reg_rd),
        .reg_rdata_ff        (reg_rdata_ff),
        .reg_rvalid_ff       (reg_rvalid_ff),
        .mclk_pin            (mclk_pin),
        .auto_scan_en        (auto_scan_en),
        .scan_round_done     (scan_round_done),
        .scan_start_ff       (scan_start_ff),
        .scan_delay_busy_ff  (scan_delay_busy_ff),
        .sar_clk_en_ff       (sar_clk_en_ff),
        .spi_read_active     (spi_read_active),
        .spi_readout_sel_ff  (spi_readout_sel_ff),
        .i2c_readout_sel_ff  (i2c_readout_sel_ff),
        .result_update_en_ff (result_update_en_ff)
    );

    // system clock
    always #5 clock = ~clock;

    // pin clock of six cycles, counts pin rises and converter ticks
    always @(posedge clock) begin
        #1;
        if (sar_clk_en_ff === 1'b1) pulses = pulses + 1;
        if (mclk_run) begin
            mph = (mph + 1) % 3;
            if (mph == 0) begin
                mclk_pin = ~mclk_pin;
                if (mclk_pin) edges = edges + 1;
            end
        end
    end

    function exp_upd(input [3:0] c);
        exp_upd = !((!c[2] && !c[3] && c[0]) || (c[2] && c[1]));
    endfunction

    task check(input [10:0] seen, input [10:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task bound(input hit);
        if (!hit) begin
            failures = failures + 1;
            $display("unexpected at %0t: wait ran out", $time);
            summarize;
        end
    endtask

    task step;
        @(posedge clock);
        #1;
    endtask

    task wr(input [7:0] a, input [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        step;
        reg_wr = 1'b0;
        step;
    endtask

    task rd(input [7:0] a, input [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        step;
        reg_rd = 1'b0;
        check(reg_rvalid_ff, 1'b1);
        check(reg_rdata_ff, v);
        step;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h8b38c6ba));
        repeat (3) step;
        rst = 1'b0;
        rd(8'h0f, 8'h40);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h01);
        rd(8'h12, 8'h00);
        rd(8'h13 + $urandom % 236, 8'h00);
        check(spi_readout_sel_ff, 1'b1);
        check(result_update_en_ff, 1'b1);
        // random writes, reserved fields written with their reset values
        for (i = 0; i < 8; i = i + 1) begin
            d = $urandom;
            wr(8'h0f, {4'h4, d[3:0]});
            rd(8'h0f, {4'h4, d[3:0]});
            wr(8'h10, 8'h00);
            rd(8'h10, 8'h00);
            wr(8'h12, {d[7:5], 5'h00});
            rd(8'h12, {d[7:5], 5'h00});
            wr(8'h11, d);
            rd(8'h11, d);
        end
        // every port, mode, hold and read-activity combination
        for (i = 0; i < 16; i = i + 1) begin
            wr(8'h12, {i[3:1], 5'h00});
            spi_read_active = i[0];
            step;
            step;
            check(result_update_en_ff, exp_upd(i[3:0]));
            check(i2c_readout_sel_ff, i[3]);
            check(spi_readout_sel_ff, !i[3]);
        end
        spi_read_active = 1'b0;
        // converter clock: oscillator ignores divider, pin path divides
        mclk_run = 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            d = i == 0 ? 8'h05 : i == 1 ? 8'h81 : i == 2 ? 8'h83 : i == 3 ? 8'h80 : 8'h82 + $urandom % 19;
            wr(8'h11, d);
            repeat (20) step;
            pulses = 0;
            edges = 0;
            repeat (800) step;
            e0 = d[7] ? edges / (d[6:0] == 0 ? 128 : d[6:0]) : 64;
            check(pulses >= e0 - 1 && pulses <= e0 + 1, 1'b1);
        end
        // scan rounds: first start, then start at once with delay off
        wr(8'h11, 8'h81);
        wr(8'h0f, 8'h40);
        auto_scan_en = 1'b1;
        step;
        check(scan_start_ff, 1'b1);
        repeat (3) step;
        scan_round_done = 1'b1;
        step;
        scan_round_done = 1'b0;
        check(scan_start_ff, 1'b1);
        // each interval code measured in base ticks
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h0f, 8'h48 | i); // reserved bits kept at reset value
            scan_round_done = 1'b1;
            step;
            scan_round_done = 1'b0;
            check(scan_delay_busy_ff, 1'b1);
            e0 = edges;
            for (k = 0; k < 12000 && scan_start_ff !== 1'b1; k = k + 1) step;
            bound(k < 12000);
            check(edges - e0 >= cmin[i] - 2 && edges - e0 <= cmin[i] + 2, 1'b1);
        end
        // delay enable cleared mid-wait starts at once; idle ignores done
        wr(8'h0f, 8'h48);
        scan_round_done = 1'b1;
        step;
        scan_round_done = 1'b0;
        check(scan_delay_busy_ff, 1'b1);
        repeat (9) step;
        wr(8'h0f, 8'h40);
        check(scan_start_ff, 1'b1);
        check(scan_delay_busy_ff, 1'b0);
        auto_scan_en = 1'b0;
        step;
        scan_round_done = 1'b1;
        step;
        scan_round_done = 1'b0;
        step;
        check(scan_start_ff, 1'b0);
        summarize;
    end
endmodule // tb_top
